// ### hdl/kr_seq_regs.sv
`timescale 1ns/1ps
`include "kr_mgmt_consts.svh"
module kr_seq_regs
#(
  // build option: advertise FEC ability from reset
  parameter bit FEC_ABILITY_AT_RESET = 1'b0
)
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // management port
  kr_mgmt_if.dev             mgmt,
  // sequencer controls
  output logic               seqRestart,
  output logic               negotiationTimerOff,
  output logic               linkFaultTimerOff,
  output logic [2:0]         forceMode,
  output logic               fecAbilityAdvertise,
  output logic               fecErrorReportEnable,
  output logic               fecRequestAdvertise,
  // sequencer status
  input  wire logic          linkReady,
  input  wire logic          negotiationTimeout,
  input  wire logic          negotiationRestart,
  input  wire logic          trainingTimeout,
  output logic               negotiationTimeoutFlag
);
  import kr_mgmt_pkg::*;

  // state and its next value
  dev_state_t  s_r;
  dev_state_t  s_nxt;
  dev_state_t  held;
  // access decode
  logic        req;
  logic        accept;
  logic        ctrlHit;
  logic        statHit;
  logic        ctrlWrite;
  logic        restartWrite;
  logic [2:0]  forceWritten;
  // read views
  logic [31:0] ctrlView;
  logic [31:0] statView;
  logic [31:0] readView;
  // negotiation timeout latch
  logic        anTimeoutFlag;
  logic        clrTimeout;

  // the latched timeout is also dropped by a management reset
  assign clrTimeout = negotiationRestart | mgmt.mgmtReset;

  // a timeout in the clearing cycle wins over the restart
  sticky_flag u_anTimeout
  (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (negotiationTimeout),
    .clr   (clrTimeout),
    .flag  (anTimeoutFlag)
  );

  assign req     = mgmt.read | mgmt.write;
  assign ctrlHit = (mgmt.addr == `SEQ_CTRL_ADDR);
  assign statHit = (mgmt.addr == `SEQ_STAT_ADDR);

  // one access per low pulse of wait-request; none is taken in reset
  // a read wins if both strobes are up, which the host never does
  assign accept = req & s_r.waitReq & ~s_r.inReset & ~mgmt.mgmtReset;
  assign ctrlWrite = accept & ~mgmt.read & ctrlHit;
  assign restartWrite = ctrlWrite & mgmt.writeData[`CTRL_RESTART_BIT];
  assign forceWritten = mgmt.writeData[`CTRL_FORCE_MSB:`CTRL_FORCE_LSB];

  // restart bit always reads back zero since it clears itself
  always_comb
  begin
    ctrlView = 32'h0;
    ctrlView[`CTRL_ANTMR_BIT] = s_r.anTimerOff;
    ctrlView[`CTRL_LFTMR_BIT] = s_r.lfTimerOff;
    ctrlView[`CTRL_FORCE_MSB:`CTRL_FORCE_LSB] = s_r.forceMode;
    ctrlView[`CTRL_FECAB_BIT] = s_r.fecAbility;
    ctrlView[`CTRL_FECERR_BIT] = s_r.fecErrReport;
    ctrlView[`CTRL_FECREQ_BIT] = s_r.fecRequest;
  end

  always_comb
  begin
    statView = 32'h0;
    statView[`STAT_LINK_BIT] = s_r.linkReady;
    statView[`STAT_ANTO_BIT] = anTimeoutFlag;
    statView[`STAT_LTTO_BIT] = s_r.trainTimeout;
  end

  // address decode of reads; unlisted addresses read zero
  always_comb
  begin
    // only the two sequencer words live here
    readView = 32'h0;
    case (mgmt.addr)
      `SEQ_CTRL_ADDR:
      begin
        readView = ctrlView;
      end
      `SEQ_STAT_ADDR:
      begin
        readView = statView;
      end
      default:
      begin
        readView = 32'h0;
      end
    endcase
  end

  // contents while the management reset level stays high
  always_comb
  begin
    held = s_r;
    held.restart = 1'b0;
    // status inputs keep flowing so the first read after reset is current
    held.linkReady = linkReady;
    held.trainTimeout = trainingTimeout;
    held.waitReq = 1'b1;
    held.readData = 32'h0;
    held.anTimerOff = 1'b0;
    held.lfTimerOff = 1'b0;
    held.forceMode = `FORCE_RESET;
    held.forceApplied = `FORCE_RESET;
    held.fecAbility = FEC_ABILITY_AT_RESET;
    held.fecErrReport = 1'b0;
    held.fecRequest = 1'b0;
    held.fecReqApplied = 1'b0;
    held.inReset = 1'b1;
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.restart = 1'b0;
    s_nxt.linkReady = linkReady;
    s_nxt.trainTimeout = trainingTimeout;
    s_nxt.inReset = 1'b0;
    if (mgmt.mgmtReset)
    begin
      s_nxt = held;
    end
    else if (accept)
    begin
      // answer one cycle later; the master holds the request meanwhile
      s_nxt.waitReq = 1'b0;
      s_nxt.readData = 32'h0;
      if (mgmt.read)
      begin
        s_nxt.readData = readView;
      end
      if (ctrlWrite)
      begin
        // only listed fields take the written value
        s_nxt.restart = mgmt.writeData[`CTRL_RESTART_BIT];
        s_nxt.anTimerOff = mgmt.writeData[`CTRL_ANTMR_BIT];
        s_nxt.lfTimerOff = mgmt.writeData[`CTRL_LFTMR_BIT];
        s_nxt.forceMode = forceWritten;
        s_nxt.fecAbility = mgmt.writeData[`CTRL_FECAB_BIT];
        s_nxt.fecErrReport = mgmt.writeData[`CTRL_FECERR_BIT];
        s_nxt.fecRequest = mgmt.writeData[`CTRL_FECREQ_BIT];
        if (restartWrite)
        begin
          // force and FEC request reach the sequencer only on restart
          s_nxt.forceApplied = forceWritten;
          s_nxt.fecReqApplied =
            mgmt.writeData[`CTRL_FECREQ_BIT];
        end
      end
      // writes to other addresses are dropped; status is read only
    end
    else
    begin
      s_nxt.waitReq = 1'b1;
    end
  end

  // same contents as a held management reset gives, except that the linkReady and trainTimeout copies start at zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.waitReq <= 1'b1;
      s_r.inReset <= 1'b1;
      s_r.fecAbility <= FEC_ABILITY_AT_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // every output is a flop: the state register or the timeout latch
  assign mgmt.waitRequest = s_r.waitReq;
  assign mgmt.readData = s_r.readData;
  assign seqRestart = s_r.restart;
  assign negotiationTimerOff = s_r.anTimerOff;
  assign linkFaultTimerOff = s_r.lfTimerOff;
  assign forceMode = s_r.forceApplied;
  assign fecAbilityAdvertise = s_r.fecAbility;
  assign fecErrorReportEnable = s_r.fecErrReport;
  assign fecRequestAdvertise = s_r.fecReqApplied;
  assign negotiationTimeoutFlag = anTimeoutFlag;
endmodule

// ### hdl/kr_mgmt_consts.svh
`ifndef KR_MGMT_CONSTS_SVH
`define KR_MGMT_CONSTS_SVH

// management map, word addresses
`define SEQ_CTRL_ADDR    8'hB0
`define SEQ_STAT_ADDR    8'hB1
`define CTRL_RESTART_BIT 0
`define CTRL_ANTMR_BIT   1
`define CTRL_LFTMR_BIT   2
`define CTRL_FORCE_LSB   4
`define CTRL_FORCE_MSB   6
`define CTRL_FECAB_BIT   16
`define CTRL_FECERR_BIT  17
`define CTRL_FECREQ_BIT  18
`define STAT_LINK_BIT    0
`define STAT_ANTO_BIT    1
`define STAT_LTTO_BIT    2
`define FORCE_NONE       3'h0
`define FORCE_GIGE       3'h3
`define FORCE_RESET      3'h0

// controller map on APB, byte addresses
`define CMD_ADDR_OFS     12'h000
`define CMD_WDATA_OFS    12'h004
`define CMD_GO_OFS       12'h008
`define CMD_RDATA_OFS    12'h00C
`define CMD_STATUS_OFS   12'h010
`define IRQ_STAT_OFS     12'h014
`define IRQ_MASK_OFS     12'h018
`define GO_START_BIT     0
`define GO_WRITE_BIT     1
`define IRQ_DONE_BIT     0
`define IRQ_BUSY_BIT     1
`define IRQ_WIDTH        2
`endif

// ### hdl/kr_mgmt_pkg.sv
package kr_mgmt_pkg;
  typedef enum logic [0:0] {M_IDLE, M_ACCESS} mstate_t;

  typedef struct packed {
    logic        waitReq;
    logic [31:0] readData;
    logic        restart;
    logic        anTimerOff;
    logic        lfTimerOff;
    logic [2:0]  forceMode;
    logic [2:0]  forceApplied;
    logic        fecAbility;
    logic        fecErrReport;
    logic        fecRequest;
    logic        fecReqApplied;
    logic        linkReady;
    logic        trainTimeout;
    logic        inReset;
  } dev_state_t;

  typedef struct packed {
    mstate_t     st;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        mWrite;
    logic        mRead;
    logic        mReset;
    logic        pready;
    logic [31:0] prdata;
    logic [1:0]  mask;
    logic        irq;
  } host_state_t;
endpackage

// ### hdl/kr_mgmt_if.sv
`timescale 1ns/1ps
interface kr_mgmt_if;
  logic        mgmtReset;
  logic [7:0]  addr;
  logic [31:0] writeData;
  logic [31:0] readData;
  logic        write;
  logic        read;
  logic        waitRequest;

  modport dev (
    input  mgmtReset,
    input  addr,
    input  writeData,
    input  write,
    input  read,
    output readData,
    output waitRequest
  );
  modport host (
    output mgmtReset,
    output addr,
    output writeData,
    output write,
    output read,
    input  readData,
    input  waitRequest
  );
endinterface

// ### hdl/sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // flag control
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);
  logic flag_r;
  logic flag_nxt;

  // an event in the clearing cycle is kept
  always_comb
  begin
    flag_nxt = set | (flag_r & ~clr);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  assign flag = flag_r;
endmodule

// ### hdl/kr_mgmt_master.sv
`timescale 1ns/1ps
`include "kr_mgmt_consts.svh"
module kr_mgmt_master
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // management port
  kr_mgmt_if.host          mgmt
);
  import kr_mgmt_pkg::*;

  host_state_t s_r;
  host_state_t s_nxt;
  logic        take;
  logic        start;
  logic        done;
  logic        refused;
  logic [1:0]  irqStat;
  logic        statRead;
  logic [31:0] rd;

  assign take = psel & penable & ~s_r.pready;
  assign start = take & pwrite & (paddr == `CMD_GO_OFS)
               & pwdata[`GO_START_BIT];
  assign refused = start & (s_r.st != M_IDLE);
  assign done = (s_r.st == M_ACCESS) & ~mgmt.waitRequest;
  // cleared at the edge that captures prdata, so no event slips between
  assign statRead = take & ~pwrite & (paddr == `IRQ_STAT_OFS);

  sticky_flag u_done
  (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (done),
    .clr   (statRead),
    .flag  (irqStat[`IRQ_DONE_BIT])
  );
  sticky_flag u_busy
  (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (refused),
    .clr   (statRead),
    .flag  (irqStat[`IRQ_BUSY_BIT])
  );

  always_comb
  begin
    rd = 32'h0;
    case (paddr)
      `CMD_ADDR_OFS:   rd = {24'h0, s_r.addr};
      `CMD_WDATA_OFS:  rd = s_r.wdata;
      `CMD_RDATA_OFS:  rd = s_r.rdata;
      `CMD_STATUS_OFS: rd = {31'h0, s_r.st == M_ACCESS};
      `IRQ_STAT_OFS:   rd = {30'h0, irqStat};
      `IRQ_MASK_OFS:   rd = {30'h0, s_r.mask};
      default:         rd = 32'h0;
    endcase
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pready = take;
    s_nxt.mReset = 1'b0;
    s_nxt.irq = |(irqStat & s_r.mask);
    if (take && !pwrite)
      s_nxt.prdata = rd;
    // settings apply at the completing edge only
    if (psel && penable && s_r.pready && pwrite)
    begin
      case (paddr)
        `CMD_ADDR_OFS:  s_nxt.addr = pwdata[7:0];
        `CMD_WDATA_OFS: s_nxt.wdata = pwdata;
        `IRQ_MASK_OFS:  s_nxt.mask = pwdata[1:0];
        default:        s_nxt.mask = s_r.mask;
      endcase
    end
    case (s_r.st)
      M_IDLE:
      begin
        // the write bit of the go word picks a write, otherwise a read
        if (start)
        begin
          s_nxt.st = M_ACCESS;
          s_nxt.mWrite = pwdata[`GO_WRITE_BIT];
          s_nxt.mRead = ~pwdata[`GO_WRITE_BIT];
        end
      end
      M_ACCESS:
      begin
        // request stays unchanged until wait-request falls
        if (done)
        begin
          s_nxt.st = M_IDLE;
          s_nxt.mWrite = 1'b0;
          s_nxt.mRead = 1'b0;
          if (s_r.mRead)
            s_nxt.rdata = mgmt.readData;
        end
      end
      default:
      begin
        s_nxt.st = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.mReset <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = 1'b0;
  assign irq = s_r.irq;
  assign mgmt.mgmtReset = s_r.mReset;
  assign mgmt.addr = s_r.addr;
  assign mgmt.writeData = s_r.wdata;
  assign mgmt.write = s_r.mWrite;
  assign mgmt.read = s_r.mRead;
endmodule

// ### bench/kr_mgmt_properties.sv
`timescale 1ns/1ps
`include "kr_mgmt_consts.svh"
module kr_mgmt_properties
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // management bus
  input wire logic        mgmtReset,
  input wire logic [7:0]  addr,
  input wire logic [31:0] writeData,
  input wire logic [31:0] readData,
  input wire logic        write,
  input wire logic        read,
  input wire logic        waitRequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  reset_hold_a: assert property (mgmtReset |=> waitRequest)
    else $error("answer during management reset");
  answer_next_a: assert property ((read || write) && waitRequest &&
    !mgmtReset |=> !waitRequest) else $error("answer late");
  answer_pulse_a: assert property (!waitRequest |=> waitRequest)
    else $error("answer longer than one cycle");
  request_hold_a: assert property ((read || write) && waitRequest |=>
    $stable(addr) && $stable(writeData) && $stable({read, write}))
    else $error("request changed while waiting");
  strobe_drop_a: assert property ((read || write) && !waitRequest
    |=> !(read || write)) else $error("strobe held after answer");
  one_dir_a: assert property (!(read && write))
    else $error("read and write together");
  unmapped_zero_a: assert property (read && !waitRequest &&
    addr != `SEQ_CTRL_ADDR && addr != `SEQ_STAT_ADDR |-> readData == 32'h0)
    else $error("unmapped read not zero");
  ctrl_spare_a: assert property (read && !waitRequest &&
    addr == `SEQ_CTRL_ADDR |-> (readData & 32'hFFF8_FF89) == 32'h0)
    else $error("control spare bits set");
  stat_spare_a: assert property (read && !waitRequest &&
    addr == `SEQ_STAT_ADDR |-> readData[31:3] == 29'h0)
    else $error("status spare bits set");
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
`include "kr_mgmt_consts.svh"
module tb;
  logic        clk = 1'b0;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        seqRestart;
  logic        anOff;
  logic        lfOff;
  logic [2:0]  forceMode;
  logic        fecAb;
  logic        fecErr;
  logic        fecReq;
  logic        linkReady;
  logic        anTo;
  logic        anRestart;
  logic        ltTo;
  logic        anFlag;
  logic [31:0] r;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          nRestart = 0;

  always #4 clk = ~clk;
  always @(posedge clk)
    if (seqRestart === 1'b1)
      nRestart <= nRestart + 1;

  kr_mgmt_if mif ();
  kr_seq_regs #(.FEC_ABILITY_AT_RESET(1'b1)) kr_seq_regs_inst (
    .clk(clk), .rst_n(rst_n), .mgmt(mif), .seqRestart(seqRestart),
    .negotiationTimerOff(anOff), .linkFaultTimerOff(lfOff),
    .forceMode(forceMode), .fecAbilityAdvertise(fecAb),
    .fecErrorReportEnable(fecErr), .fecRequestAdvertise(fecReq),
    .linkReady(linkReady), .negotiationTimeout(anTo),
    .negotiationRestart(anRestart), .trainingTimeout(ltTo),
    .negotiationTimeoutFlag(anFlag));
  kr_mgmt_master kr_mgmt_master_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .mgmt(mif));
  kr_mgmt_properties kr_mgmt_properties_inst (
    .clk(clk), .rst_n(rst_n), .mgmtReset(mif.mgmtReset), .addr(mif.addr),
    .writeData(mif.writeData), .readData(mif.readData),
    .write(mif.write), .read(mif.read), .waitRequest(mif.waitRequest));

  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until pready is sampled high
  task automatic apb(input bit wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 64);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_errors++;
      report_and_stop();
    end
  endtask

  task automatic mgmt(input bit wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    logic [31:0] s;
    int          i;
    apb(1'b1, `CMD_ADDR_OFS, {24'h0, a}, s);
    apb(1'b1, `CMD_WDATA_OFS, d, s);
    apb(1'b1, `CMD_GO_OFS, {30'h0, wr, 1'b1}, s);
    i = 0;
    do
    begin
      apb(1'b0, `CMD_STATUS_OFS, 32'h0, s);
      i++;
    end
    while (s[0] !== 1'b0 && i < 16);
    if (s[0] !== 1'b0)
    begin
      n_errors++;
      report_and_stop();
    end
    apb(1'b0, `CMD_RDATA_OFS, 32'h0, q);
  endtask

  task automatic reset_seq;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    {linkReady, anTo, anRestart, ltTo} <= '0;
    reset_seq();
    mgmt(1'b0, `SEQ_CTRL_ADDR, 32'h0, r);
    check(r, 32'h0001_0000);
    mgmt(1'b0, `SEQ_STAT_ADDR, 32'h0, r);
    check(r, 32'h0);
    check({31'h0, fecAb}, 32'h1);
    // all ones but the restart bit and spare bit 3: spare bits dropped, force and request wait for restart
    mgmt(1'b1, `SEQ_CTRL_ADDR, 32'hFFFF_FFF6, r);
    mgmt(1'b0, `SEQ_CTRL_ADDR, 32'h0, r);
    check(r, 32'h0007_0076);
    check({28'h0, anOff, lfOff, fecErr, fecReq}, 32'hE);
    check({29'h0, forceMode}, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      mgmt(1'b1, `SEQ_CTRL_ADDR, {13'h0, 3'h7, 9'h0, 3'(c), 4'h1}, r);
      check({29'h0, forceMode}, 32'(c));
    end
    check(nRestart, 32'h8);
    check({31'h0, fecReq}, 32'h1);
    mgmt(1'b0, `SEQ_CTRL_ADDR, 32'h0, r);
    check(r, 32'h0007_0070);
    check({30'h0, anOff, lfOff}, 32'h0);
    linkReady <= 1'b1;
    ltTo <= 1'b1;
    anTo <= 1'b1;
    @(posedge clk);
    anTo <= 1'b0;
    mgmt(1'b0, `SEQ_STAT_ADDR, 32'h0, r);
    check(r, 32'h7);
    check({31'h0, anFlag}, 32'h1);
    linkReady <= 1'b0;
    ltTo <= 1'b0;
    mgmt(1'b0, `SEQ_STAT_ADDR, 32'h0, r);
    check(r, 32'h2);
    anRestart <= 1'b1;
    @(posedge clk);
    anRestart <= 1'b0;
    mgmt(1'b1, `SEQ_STAT_ADDR, 32'hFFFF_FFFF, r);
    mgmt(1'b0, `SEQ_STAT_ADDR, 32'h0, r);
    check(r, 32'h0);
    mgmt(1'b1, 8'h55, 32'hFFFF_FFFF, r);
    mgmt(1'b0, 8'h55, 32'h0, r);
    check(r, 32'h0);
    apb(1'b0, 12'h040, 32'h0, r);
    check(r, 32'h0);
    check({31'h0, pslverr}, 32'h0);
    // done is sticky: unmasking raises irq, reading status clears it
    apb(1'b1, `IRQ_MASK_OFS, 32'h1, r);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, `IRQ_STAT_OFS, 32'h0, r);
    check(r, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    mgmt(1'b0, `SEQ_CTRL_ADDR, 32'h0, r);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `IRQ_MASK_OFS, 32'h0, r);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    reset_seq();
    mgmt(1'b0, `SEQ_CTRL_ADDR, 32'h0, r);
    check(r, 32'h0001_0000);
    check({29'h0, forceMode}, 32'h0);
    report_and_stop();
  end
endmodule
